// *** src/opr_ctrl.sv ***
`timescale 1ns/1ns
module opr_ctrl
   import opr_pkg::*;
#(
   parameter int INIT_PULSE_CYC  = C_INIT_PULSE,
   parameter int BRUTE_PULSE_CYC = C_BRUTE_PULSE,
   parameter int OVER_UNIT_CYC   = OVERPROG_FACTOR * INIT_PULSE_CYC,
   parameter int BLANK_STEP_CYC  = C_VER_VALID
) (
   input  wire logic              mclk,
   input  wire logic              nrst,
   input  wire logic              cmd_valid,
   input  wire opr_op_e           cmd_op,
   input  wire logic              cmd_brute,
   input  wire logic [ADDR_W-1:0] cmd_addr,
   input  wire logic [DATA_W-1:0] cmd_data,
   output logic                   cmd_ready_q,
   output logic                   done_q,
   output logic                   ok_q,
   output logic [DATA_W-1:0]      rdata_q,
   output logic [2:0]             pulses_q,
   output logic                   all_written_q,
   output logic [ADDR_W-1:0]      pin_addr_q,
   output logic                   sel1_n_q,
   output logic                   sel2_n_q,
   output logic                   supervoltage_pin_q,
   output logic                   verify_strobe_n_q,
   output logic                   program_strobe_n_q,
   output logic                   strobe_vpp_q,
   output logic                   prog_level_q,
   input  wire logic [DATA_W-1:0] data_in,
   output logic [DATA_W-1:0]      data_out_q,
   output logic                   data_oe_q
);
   if (INIT_PULSE_CYC < 1 || BRUTE_PULSE_CYC < 1 || OVER_UNIT_CYC < 1 || BLANK_STEP_CYC < 1 ||
       BRUTE_PULSE_CYC >= 2**TMR_W || OVER_UNIT_CYC * MAX_INIT_PULSES >= 2**TMR_W)
   begin : g_bad_cyc
      $error("opr_ctrl: pulse counts do not fit the timer");
   end

   opr_state_e          state_q, state_d;
   opr_op_e             op_q, op_d;
   logic                brute_q, over_q;
   logic [DATA_W-1:0]   wdata_q;
   logic                tmr_start, tmr_exp;
   logic [TMR_W-1:0]    tmr_len, pulse_len;
   logic [NUM_WORDS-1:0] written_q;
   logic [CNT_W-1:0]    written_cnt_q;
   logic                blank_op, ver_match;

   function automatic logic is_blank(input opr_op_e op);
      return (op == OP_BLANK_ONES) || (op == OP_BLANK_ZEROS);
   endfunction

   function automatic logic [DATA_W-1:0] blank_expect(input opr_op_e op);
      return (op == OP_BLANK_ONES) ? ALL_ONES : ALL_ZEROS;
   endfunction

   opr_timer #(.W(TMR_W)) u_timer (
      .mclk     (mclk),
      .nrst     (nrst),
      .start    (tmr_start),
      .len      (tmr_len),
      .expire_q (tmr_exp)
   );

   assign blank_op  = is_blank(op_q);
   assign ver_match = (rdata_q == wdata_q);

   always_comb begin
      if (brute_q) begin
         pulse_len = TMR_W'(BRUTE_PULSE_CYC);
      end else if (over_q) begin
         pulse_len = TMR_W'(OVER_UNIT_CYC * int'(pulses_q));
      end else begin
         pulse_len = TMR_W'(INIT_PULSE_CYC);
      end
   end

   always_comb begin
      state_d   = state_q;
      tmr_start = 1'b0;
      tmr_len   = '0;
      op_d      = (state_q == S_IDLE && cmd_valid) ? cmd_op : op_q;
      case (state_q)
         S_IDLE: if (cmd_valid) begin
            tmr_start = 1'b1;
            if (cmd_op == OP_READ) begin
               state_d = S_RD_WAIT;
               tmr_len = TMR_W'(C_ACCESS);
            end else begin
               state_d = S_PREP;
               tmr_len = TMR_W'(C_VPP_EDGE);
            end
         end
         S_RD_WAIT: if (tmr_exp) begin
            state_d = S_IDLE;
         end
         S_PREP: if (tmr_exp) begin
            state_d   = S_VPP_UP;
            tmr_start = 1'b1;
            tmr_len   = TMR_W'(C_VPP_EDGE);
         end
         S_VPP_UP: if (tmr_exp) begin
            tmr_start = 1'b1;
            state_d   = blank_op ? S_BK_WAIT : S_SETUP;
            tmr_len   = blank_op ? TMR_W'(BLANK_STEP_CYC) : TMR_W'(C_SETUP);
         end
         S_BK_WAIT: if (tmr_exp) begin
            tmr_start = 1'b1;
            if (pin_addr_q == LAST_ADDR) begin
               state_d = S_VPP_DOWN;
               tmr_len = TMR_W'(C_VPP_EDGE);
            end else begin
               // step is a parameter: a full sweep at the data-valid time is long
               tmr_len = TMR_W'(BLANK_STEP_CYC);
            end
         end
         S_SETUP: if (tmr_exp) begin
            state_d   = S_PULSE;
            tmr_start = 1'b1;
            tmr_len   = pulse_len;
         end
         S_PULSE: if (tmr_exp) begin
            state_d   = S_HOLD;
            tmr_start = 1'b1;
            tmr_len   = TMR_W'(C_HOLD);
         end
         S_HOLD: if (tmr_exp) begin
            tmr_start = 1'b1;
            state_d   = over_q ? S_VPP_DOWN : S_VER_DLY;
            tmr_len   = over_q ? TMR_W'(C_VPP_EDGE) : TMR_W'(C_VER_DELAY);
         end
         S_VER_DLY: if (tmr_exp) begin
            state_d   = S_VER;
            tmr_start = 1'b1;
            tmr_len   = TMR_W'(C_VER_PULSE);
         end
         S_VER: if (tmr_exp) begin
            state_d   = S_VER_END;
            tmr_start = 1'b1;
            tmr_len   = TMR_W'(C_VER_HIZ);
         end
         S_VER_END: if (tmr_exp) begin
            tmr_start = 1'b1;
            // a good intelligent verify loops once more for the overprogram
            if (brute_q || (!ver_match && pulses_q == MAX_PULSES_V)) begin
               state_d = S_VPP_DOWN;
               tmr_len = TMR_W'(C_VPP_EDGE);
            end else begin
               state_d = S_SETUP;
               tmr_len = TMR_W'(C_SETUP);
            end
         end
         S_VPP_DOWN: if (tmr_exp) begin
            state_d = S_IDLE;
         end
         default: state_d = S_IDLE;
      endcase
   end

   always_ff @(posedge mclk) begin
      if (!nrst) begin
         state_q <= S_IDLE;
         op_q    <= OP_READ;
      end else begin
         state_q <= state_d;
         op_q    <= op_d;
      end
   end

   // pins follow the next state so they line up with state_q
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         sel1_n_q           <= 1'b1;
         sel2_n_q           <= 1'b1;
         supervoltage_pin_q <= 1'b0;
         verify_strobe_n_q  <= 1'b0;
         program_strobe_n_q <= 1'b0;
         strobe_vpp_q       <= 1'b0;
         prog_level_q       <= 1'b0;
      end else begin
         sel1_n_q           <= 1'b1;
         sel2_n_q           <= 1'b1;
         supervoltage_pin_q <= 1'b0;
         verify_strobe_n_q  <= 1'b0;
         program_strobe_n_q <= 1'b0;
         strobe_vpp_q       <= 1'b0;
         prog_level_q       <= 1'b1;
         case (state_d)
            S_IDLE: prog_level_q <= 1'b0;
            S_RD_WAIT: begin
               sel1_n_q           <= 1'b0;
               sel2_n_q           <= 1'b0;
               verify_strobe_n_q  <= 1'b1;
               program_strobe_n_q <= 1'b1;
               prog_level_q       <= 1'b0;
            end
            S_PREP, S_VPP_DOWN: begin
               verify_strobe_n_q  <= 1'b1;
               program_strobe_n_q <= 1'b1;
            end
            S_VPP_UP, S_BK_WAIT: if (is_blank(op_d)) begin
               sel1_n_q          <= 1'b0;
               sel2_n_q          <= 1'b0;
               strobe_vpp_q      <= 1'b1;
               verify_strobe_n_q <= (op_d == OP_BLANK_ZEROS);
            end else begin
               supervoltage_pin_q <= 1'b1;
               verify_strobe_n_q  <= 1'b1;
               program_strobe_n_q <= 1'b1;
            end
            default: begin
               sel1_n_q           <= 1'b0;
               supervoltage_pin_q <= 1'b1;
               verify_strobe_n_q  <= (state_d != S_VER);
               program_strobe_n_q <= (state_d != S_PULSE);
            end
         endcase
      end
   end

   // data lines driven only across setup, pulse and hold
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         data_oe_q  <= 1'b0;
         data_out_q <= ALL_ZEROS;
      end else if (state_d == S_SETUP || state_d == S_PULSE || state_d == S_HOLD) begin
         data_oe_q  <= 1'b1;
         data_out_q <= wdata_q;
      end else begin
         data_oe_q  <= 1'b0;
         data_out_q <= ALL_ZEROS;
      end
   end

   always_ff @(posedge mclk) begin
      if (!nrst) begin
         brute_q    <= 1'b0;
         over_q     <= 1'b0;
         wdata_q    <= ALL_ZEROS;
         ok_q       <= 1'b0;
         rdata_q    <= ALL_ZEROS;
         pulses_q   <= 3'h0;
         pin_addr_q <= '0;
      end else begin
         case (state_q)
            S_IDLE: if (cmd_valid) begin
               brute_q    <= cmd_brute;
               over_q     <= 1'b0;
               wdata_q    <= is_blank(cmd_op) ? blank_expect(cmd_op) : cmd_data;
               ok_q       <= 1'b1;
               pulses_q   <= 3'h0;
               pin_addr_q <= is_blank(cmd_op) ? '0 : cmd_addr;
            end
            S_RD_WAIT: if (tmr_exp) begin
               rdata_q <= data_in;
               ok_q    <= (data_in == wdata_q);
            end
            S_BK_WAIT: if (tmr_exp) begin
               rdata_q <= data_in;
               if (data_in != wdata_q) begin
                  ok_q <= 1'b0;
               end
               if (pin_addr_q != LAST_ADDR) begin
                  pin_addr_q <= pin_addr_q + 1'b1;
               end
            end
            S_PULSE: if (tmr_exp && !over_q && !brute_q) begin
               pulses_q <= pulses_q + 3'h1;
            end
            S_VER: if (tmr_exp) begin
               rdata_q <= data_in;
            end
            S_VER_END: if (tmr_exp) begin
               if (ver_match && !brute_q) begin
                  over_q <= 1'b1;
               end else if (!ver_match && (brute_q || pulses_q == MAX_PULSES_V)) begin
                  ok_q <= 1'b0;
               end
            end
            default: ;
         endcase
      end
   end

   always_ff @(posedge mclk) begin
      if (!nrst) begin
         done_q      <= 1'b0;
         cmd_ready_q <= 1'b0;
      end else begin
         done_q      <= tmr_exp && (state_q == S_RD_WAIT || state_q == S_VPP_DOWN);
         cmd_ready_q <= (state_d == S_IDLE);
      end
   end

   // tracks coverage of the array so software can see nothing stays erased
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         written_q     <= '0;
         written_cnt_q <= '0;
         all_written_q <= 1'b0;
      end else begin
         if (state_q == S_VPP_DOWN && tmr_exp && op_q == OP_PROGRAM && ok_q &&
             !written_q[pin_addr_q]) begin
            written_q[pin_addr_q] <= 1'b1;
            written_cnt_q         <= written_cnt_q + 1'b1;
         end
         all_written_q <= (written_cnt_q == CNT_W'(NUM_WORDS));
      end
   end

   // checks
   logic [TMR_W-1:0] low_cnt_q;
   always_ff @(posedge mclk) begin
      if (!nrst || program_strobe_n_q || !prog_level_q) begin
         low_cnt_q <= '0;
      end else begin
         low_cnt_q <= low_cnt_q + 1'b1;
      end
   end

   default clocking cb @(posedge mclk); endclocking
   default disable iff (!nrst);

   chk_read_selects: assert property (
      state_q == S_RD_WAIT |-> !sel1_n_q && !sel2_n_q && verify_strobe_n_q &&
                               program_strobe_n_q && !supervoltage_pin_q)
      else $error("read selects wrong");
   chk_vpp_entry: assert property (
      $rose(supervoltage_pin_q) |-> $past(program_strobe_n_q) &&
         $past(verify_strobe_n_q) && $past(sel1_n_q) && $past(sel2_n_q) &&
         program_strobe_n_q && verify_strobe_n_q && sel1_n_q)
      else $error("supervoltage raised before all high");
   chk_addr_stable: assert property (
      supervoltage_pin_q && $past(supervoltage_pin_q) |-> $stable(pin_addr_q))
      else $error("address moved under supervoltage");
   // supervoltage separates a pulse end from the strobe rise at entry or blank exit
   chk_brute_width: assert property (
      $rose(program_strobe_n_q) && supervoltage_pin_q && brute_q |->
         low_cnt_q == TMR_W'(BRUTE_PULSE_CYC + 1))
      else $error("brute pulse width wrong");
   chk_init_width: assert property (
      $rose(program_strobe_n_q) && supervoltage_pin_q && !brute_q && !over_q |->
         low_cnt_q == TMR_W'(INIT_PULSE_CYC + 1))
      else $error("initial pulse width wrong");
   chk_pulse_limit: assert property (
      pulses_q <= MAX_PULSES_V)
      else $error("too many initial pulses");
   chk_over_follows: assert property (
      state_q == S_VER_END && tmr_exp && ver_match && !brute_q |=>
         over_q && state_q == S_SETUP ##1 (state_q == S_SETUP)[*8])
      else $error("no overprogram after good verify");
   chk_over_width: assert property (
      $rose(program_strobe_n_q) && supervoltage_pin_q && over_q |->
         low_cnt_q == TMR_W'(OVER_UNIT_CYC * int'(pulses_q) + 1))
      else $error("overprogram width wrong");
   chk_blank_step: assert property (
      state_q == S_BK_WAIT && tmr_exp && pin_addr_q != LAST_ADDR |=>
         pin_addr_q == $past(pin_addr_q) + 1'b1)
      else $error("blank sweep skipped an address");
   chk_idle_data: assert property (
      !data_oe_q |-> data_out_q == ALL_ZEROS)
      else $error("undriven data not low");
   chk_program_mode: assert property (
      !program_strobe_n_q && prog_level_q && !strobe_vpp_q |-> data_oe_q && supervoltage_pin_q &&
         !sel1_n_q && verify_strobe_n_q)
      else $error("program pulse outside program mode");

   cov_read: cover property (state_q == S_RD_WAIT && tmr_exp);
   cov_over: cover property ($rose(over_q));
   cov_blank: cover property (state_q == S_BK_WAIT && tmr_exp && pin_addr_q == LAST_ADDR);
   cov_fail: cover property (done_q && !ok_q && op_q == OP_PROGRAM);
endmodule

// *** src/opr_pkg.sv ***
package opr_pkg;
   localparam int ADDR_W      = 10;
   localparam int DATA_W      = 8;
   localparam int NUM_WORDS   = 1024;
   localparam int CNT_W       = 11;
   localparam int TMR_W       = 22;
   localparam int CLK_MHZ     = 125;
   localparam logic [ADDR_W-1:0] LAST_ADDR = 10'h3FF;
   localparam logic [DATA_W-1:0] ALL_ONES  = 8'hFF;
   localparam logic [DATA_W-1:0] ALL_ZEROS = 8'h00;

   // pulse figures in their own units
   localparam int T_INIT_PULSE_US  = 100;
   localparam int T_BRUTE_PULSE_US = 10000;
   localparam int OVERPROG_FACTOR  = 24;
   localparam int MAX_INIT_PULSES  = 4;
   localparam logic [2:0] MAX_PULSES_V = 3'h4;

   // setup, hold and verify spacing, all least times
   localparam int T_SETUP_US      = 1;
   localparam int T_HOLD_US       = 1;
   localparam int T_VPP_EDGE_US   = 1;
   localparam int T_VER_DELAY_US  = 1;
   localparam int T_VER_PULSE_US  = 2;
   localparam int T_VER_VALID_US  = 1;
   localparam int T_VER_HIZ_US    = 1;
   localparam int T_ACCESS_NS     = 45;

   localparam int C_INIT_PULSE  = T_INIT_PULSE_US * CLK_MHZ;
   localparam int C_BRUTE_PULSE = T_BRUTE_PULSE_US * CLK_MHZ;
   localparam int C_SETUP       = T_SETUP_US * CLK_MHZ;
   localparam int C_HOLD        = T_HOLD_US * CLK_MHZ;
   localparam int C_VPP_EDGE    = T_VPP_EDGE_US * CLK_MHZ;
   localparam int C_VER_DELAY   = T_VER_DELAY_US * CLK_MHZ;
   localparam int C_VER_PULSE   = T_VER_PULSE_US * CLK_MHZ;
   localparam int C_VER_VALID   = T_VER_VALID_US * CLK_MHZ;
   localparam int C_VER_HIZ     = T_VER_HIZ_US * CLK_MHZ;
   localparam int C_ACCESS      = (T_ACCESS_NS * CLK_MHZ + 999) / 1000;

   typedef enum logic [1:0] {
      OP_READ        = 2'h0,
      OP_PROGRAM     = 2'h1,
      OP_BLANK_ONES  = 2'h2,
      OP_BLANK_ZEROS = 2'h3
   } opr_op_e;

   typedef enum logic [11:0] {
      S_IDLE     = 12'h001,
      S_RD_WAIT  = 12'h002,
      S_PREP     = 12'h004,
      S_VPP_UP   = 12'h008,
      S_BK_WAIT  = 12'h010,
      S_SETUP    = 12'h020,
      S_PULSE    = 12'h040,
      S_HOLD     = 12'h080,
      S_VER_DLY  = 12'h100,
      S_VER      = 12'h200,
      S_VER_END  = 12'h400,
      S_VPP_DOWN = 12'h800
   } opr_state_e;
endpackage

// *** src/opr_timer.sv ***
`timescale 1ns/1ns
module opr_timer
   import opr_pkg::*;
#(
   parameter int W = TMR_W
) (
   input  wire logic         mclk,
   input  wire logic         nrst,
   input  wire logic         start,
   input  wire logic [W-1:0] len,
   output logic              expire_q
);
   logic [W-1:0] cnt_q;

   if (W < 2) begin : g_bad_w
      $error("opr_timer: W too small");
   end

   // expire shows len cycles after start, so every wait is at least len
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         cnt_q <= '0;
      end else if (start) begin
         cnt_q <= len;
      end else if (cnt_q != '0) begin
         cnt_q <= cnt_q - 1'b1;
      end
   end

   always_ff @(posedge mclk) begin
      if (!nrst) begin
         expire_q <= 1'b0;
      end else begin
         expire_q <= !start && (cnt_q == W'(1));
      end
   end
endmodule

// *** verification/opr_prom_model.sv ***
`timescale 1ns/1ns
module opr_prom_model
   import opr_pkg::*;
(
   input  wire logic              mclk,
   input  wire logic [ADDR_W-1:0] pin_addr,
   input  wire logic              sel1_n,
   input  wire logic              sel2_n,
   input  wire logic              vpp,
   input  wire logic              pin19,
   input  wire logic              pin18,
   input  wire logic              pin18_vpp,
   input  wire logic [DATA_W-1:0] data_out,
   input  wire logic              data_oe,
   input  wire logic [2:0]        need,
   output logic [DATA_W-1:0]      data_in,
   output logic [3:0]             npulse_q,
   output int                     len_q
);
   logic [DATA_W-1:0] mem_q [NUM_WORDS];
   logic              set_q [NUM_WORDS];
   logic [DATA_W-1:0] last_q;
   logic [DATA_W-1:0] wbyte_q;
   logic              p18_q;
   logic              vpp_q;
   int                run_q;
   wire rd  = !sel1_n && !sel2_n && !vpp && pin19 && pin18 && !pin18_vpp;
   wire pv  = vpp && !sel1_n;
   wire verify_strobe = pv && pin18 && !pin19;
   wire blk = pin18_vpp && !vpp && !sel1_n && !sel2_n;
   initial begin
      foreach (set_q[i]) set_q[i] = 1'b0;
      npulse_q = '0;
      run_q = 0;
      len_q = 0;
   end
   // unset cells flip each cycle when read or undriven, show ~wbyte_q in verify and !pin19 in a blank check
   always_comb begin
      if (rd) data_in = set_q[pin_addr] ? mem_q[pin_addr] : ~last_q;
      else if (verify_strobe) data_in = set_q[pin_addr] ? mem_q[pin_addr] : ~wbyte_q;
      else if (blk) data_in = set_q[pin_addr] ? mem_q[pin_addr] : {DATA_W{!pin19}};
      else data_in = ~last_q;
   end
   // a cell takes only after need pulses, so slow cells can be modelled
   always @(posedge mclk) begin
      last_q <= data_in;
      p18_q <= pin18;
      vpp_q <= vpp;
      if (vpp && !vpp_q) npulse_q <= '0;
      if (pv && !pin18 && pin19) begin
         run_q <= run_q + 1;
         if (data_oe) wbyte_q <= data_out;
      end
      if (pv && pin18 && !p18_q) begin
         npulse_q <= npulse_q + 4'h1;
         len_q <= run_q;
         run_q <= 0;
         if (npulse_q + 4'h1 >= need) begin
            mem_q[pin_addr] <= wbyte_q;
            set_q[pin_addr] <= 1'b1;
         end
      end
   end
endmodule

// *** verification/tb.sv ***
`timescale 1ns/1ns
module tb
   import opr_pkg::*;
;
   localparam int INIT = 20;
   localparam int OVER = 480;
   localparam int LIMIT = 30000;
   localparam int STEP = 20;
   logic              mclk;
   logic              nrst;
   logic              cmd_valid;
   opr_op_e           cmd_op;
   logic              cmd_brute;
   logic [ADDR_W-1:0] cmd_addr;
   logic [DATA_W-1:0] cmd_data;
   logic              cmd_ready_q;
   logic              done_q;
   logic              ok_q;
   logic [DATA_W-1:0] rdata_q;
   logic [2:0]        pulses_q;
   logic [ADDR_W-1:0] pin_addr_q;
   logic              sel1_n_q;
   logic              sel2_n_q;
   logic              vpp_q;
   logic              vstb_n_q;
   logic              pstb_n_q;
   logic              all_wr_q;
   logic              lvl_q;
   logic              svpp_q;
   logic [DATA_W-1:0] data_in;
   logic [DATA_W-1:0] data_out_q;
   logic              data_oe_q;
   logic [2:0]        need;
   logic [3:0]        npulse;
   int                plen;
   int                cyc;
   logic [3:0]        snap;
   int                err_count = 0;
   int                comparisons = 0;

   opr_ctrl #(.INIT_PULSE_CYC(INIT), .BRUTE_PULSE_CYC(40), .OVER_UNIT_CYC(OVER),
              .BLANK_STEP_CYC(STEP)) i_dut (
      .mclk(mclk), .nrst(nrst), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
      .cmd_brute(cmd_brute), .cmd_addr(cmd_addr), .cmd_data(cmd_data),
      .cmd_ready_q(cmd_ready_q), .done_q(done_q), .ok_q(ok_q), .rdata_q(rdata_q),
      .pulses_q(pulses_q), .all_written_q(all_wr_q), .pin_addr_q(pin_addr_q),
      .sel1_n_q(sel1_n_q), .sel2_n_q(sel2_n_q), .supervoltage_pin_q(vpp_q),
      .verify_strobe_n_q(vstb_n_q), .program_strobe_n_q(pstb_n_q),
      .strobe_vpp_q(svpp_q), .prog_level_q(lvl_q), .data_in(data_in),
      .data_out_q(data_out_q), .data_oe_q(data_oe_q));

   opr_prom_model i_prom (
      .mclk(mclk), .pin_addr(pin_addr_q), .sel1_n(sel1_n_q), .sel2_n(sel2_n_q),
      .vpp(vpp_q), .pin19(vstb_n_q), .pin18(pstb_n_q), .pin18_vpp(svpp_q),
      .data_out(data_out_q), .data_oe(data_oe_q), .need(need), .data_in(data_in),
      .npulse_q(npulse), .len_q(plen));

   always #4 mclk = ~mclk;

   task automatic print_verdict;
      $display("comparisons %0d mismatches %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         err_count++;
         $display("BAD %s exp %0h seen %0h", nm, exp, seen);
      end
   endtask

   task automatic run(input opr_op_e op, input logic br, input logic [ADDR_W-1:0] a,
                      input logic [DATA_W-1:0] d);
      @(posedge mclk);
      #1;
      // ready is read settled, then the request stands over exactly one edge
      while (cmd_ready_q !== 1'b1) begin
         @(posedge mclk);
         #1;
      end
      cmd_valid = 1'b1;
      cmd_op = op;
      cmd_brute = br;
      cmd_addr = a;
      cmd_data = d;
      @(posedge mclk);
      #1;
      cmd_valid = 1'b0;
      cyc = 0;
      while (done_q !== 1'b1 && cyc < LIMIT) begin
         @(posedge mclk);
         #1;
         cyc++;
         if (cyc == 2) snap = {sel1_n_q, sel2_n_q, vstb_n_q, pstb_n_q};
      end
      if (cyc >= LIMIT) err_count++;
      chk("idle sel1", sel1_n_q, 1);
      chk("idle oe", data_oe_q, 0);
      chk("idle vpp", vpp_q, 0);
      chk("idle level", lvl_q, 0);
   endtask

   task automatic t_prog(input logic br, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
                         input logic [2:0] nd, input logic eok, input int enp, input int elen);
      need = nd;
      run(OP_PROGRAM, br, a, d);
      chk("prog ok", ok_q, eok);
      if (!br) chk("pulses", pulses_q, nd > 4 ? 4 : nd);
      chk("pulse count", npulse, enp);
      chk("last pulse", plen, elen);
      chk("all written", all_wr_q, 0);
      $display("done program");
   endtask

   task automatic t_read(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
                         input logic eok, input logic [DATA_W-1:0] erd);
      run(OP_READ, 1'b0, a, d);
      chk("read time", cyc, C_ACCESS + 1);
      chk("read pins", snap, 4'h3);
      chk("read ok", ok_q, eok);
      chk("read data", rdata_q, erd);
      $display("done read");
   endtask

   task automatic t_blank(input opr_op_e op, input logic eok);
      run(op, 1'b0, '0, '0);
      chk("blank ok", ok_q, eok);
      $display("done blank");
   endtask

   initial begin
      #(8 * 80000);
      err_count++;
      print_verdict;
   end

   initial begin
      mclk = 1'b0;
      nrst = 1'b0;
      cmd_valid = 1'b0;
      cmd_op = OP_READ;
      cmd_brute = 1'b0;
      cmd_addr = '0;
      cmd_data = '0;
      need = 3'h1;
      repeat (10) @(posedge mclk);
      #1;
      chk("reset sel1", sel1_n_q, 1);
      chk("reset oe", data_oe_q, 0);
      chk("reset ready", cmd_ready_q, 0);
      nrst = 1'b1;
      @(posedge mclk);
      #1;
      chk("ready", cmd_ready_q, 1);
      $display("done reset");
      t_blank(OP_BLANK_ONES, 1'b1);
      t_prog(1'b0, 10'h3FF, 8'hA5, 3'h1, 1'b1, 2, OVER + 1);
      t_prog(1'b0, 10'h000, 8'h5A, 3'h3, 1'b1, 4, 3 * OVER + 1);
      t_prog(1'b0, 10'h001, 8'hC3, 3'h5, 1'b0, 4, INIT + 1);
      t_prog(1'b1, 10'h002, 8'h0F, 3'h1, 1'b1, 1, 41);
      t_read(10'h3FF, 8'hA5, 1'b1, 8'hA5);
      t_read(10'h000, 8'h00, 1'b0, 8'h5A);
      t_blank(OP_BLANK_ZEROS, 1'b0);
      print_verdict;
   end
endmodule
